// file: smsp_defs.svh
// register map, field positions, reset values and timing counts of the spi port
`ifndef SMSP_DEFS_SVH
`define SMSP_DEFS_SVH
`define SMSP_CTRL_OFS 8'h00
`define SMSP_STAT_OFS 8'h04
`define SMSP_DATA_OFS 8'h08
`define SMSP_CTRL_RST 8'h00
`define SMSP_BYTE_RST 8'h00
`define SMSP_PIN_RST 4'h2
`define SMSP_ST_DONE 7
`define SMSP_ST_OVR 6
`define SMSP_ST_FAULT 4
`define SMSP_ST_TXE 3
`define SMSP_LAST_EDGE 5'h0F
`define SMSP_RATE_OFF_LO 3'h0
`define SMSP_RATE_OFF_HI 3'h7
`define SMSP_RESP_OKAY 2'h0
`define SMSP_RESP_SLVERR 2'h2
`endif

// file: smsp_pkg.sv
// types shared by the spi master/slave port
package smsp_pkg;
	typedef enum logic [1:0] {
		smsp_idle = 2'b00,
		smsp_run = 2'b01
	} smsp_state_t;
	typedef struct packed {
		logic rate_sel_bit2;
		logic port_enable;
		logic select_disable;
		logic master_select;
		logic clk_pol;
		logic clk_pha;
		logic rate_sel_bit1;
		logic rate_sel_bit0;
	} smsp_ctrl_t;
endpackage

// file: smsp_core.sv
// spi master/slave port with an axi4-lite register slave
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "smsp_defs.svh"
// Operation
// - slave-to-master bytes are 8 bits, most significant bit first.
// - one transfer is exactly eight serial clocks, one byte each way.
// - unselected slave puts its data output in high impedance.
// - master with select disabled frees select; mode fault never sets.
// - slave with phase 1 and select disabled is always selected.
// - mode fault clears after status read with flag set, then control write.
// - rate field picks divisor 4 to 128; codes 000 and 111 unused.
// - master mode by master select; a data write starts the transfer.
// - on completion set done flag and load receive data together.
// - done clears after status read with flag set, then data read.
// - slave copies a full byte to receive data and sets done at once.
// - late slave write means the old shift register contents are sent.
// - polarity sets serial clock idle level; phase picks sample and shift edges.
// - phase 0 samples on first edge; select falls to start, toggles between bytes.
// - phase 1 drives on first edge, which starts the slave; select may stay low.
// - buffer empty flag tracks the one-byte buffer; queued byte follows without gap.
// - slave with no new byte sends the last received byte.
// - master-to-slave line carries bytes most significant bit first.
// - byte arriving over unread data is dropped, old kept, overrun flagged.
module smsp_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic ss_n_in
);
	localparam logic [3:0] pin_rst = `SMSP_PIN_RST;

	function automatic logic [6:0] half_of(input logic [2:0] rate);
		half_of = 7'h01 << rate;
	endfunction

	// pin synchronisers: 0 sck, 1 select, 2 mosi, 3 miso
	logic [3:0] pin_raw, sync1_r, sync2_r, sync3_r, pin_stb_r, pin_chg;
	assign pin_raw = {miso_in, mosi_in, ss_n_in, sck_in};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sync1_r[gi] <= pin_rst[gi];
					sync2_r[gi] <= pin_rst[gi];
					sync3_r[gi] <= pin_rst[gi];
					pin_stb_r[gi] <= pin_rst[gi];
				end else begin
					sync1_r[gi] <= pin_raw[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync3_r[gi] <= sync2_r[gi];
					if (sync2_r[gi] == sync3_r[gi]) begin
						pin_stb_r[gi] <= sync3_r[gi];
					end
				end
			end
			assign pin_chg[gi] = (sync2_r[gi] == sync3_r[gi]) && (sync3_r[gi] != pin_stb_r[gi]);
		end
	endgenerate

	smsp_pkg::smsp_ctrl_t ctrl_r, ctrl_nxt;
	smsp_pkg::smsp_state_t state_r, state_nxt;
	logic [7:0] sh_r, sh_nxt, buf_r, rx_r;
	logic [4:0] ecnt_r;
	logic [6:0] div_r;
	logic txe_r, done_r, ovr_r, fault_r, arm_done_r, arm_fault_r, rxb_r, sck_r, sck_nxt;
	logic [2:0] rate;
	logic rate_ok, is_m, is_s, sel, div_tick, edge_ev, lead, samp, last, din, shift_in, miso_now;
	logic start_m, load_idle, load_next, fault_m, fault_s;
	logic [7:0] rx_byte;

	// axi side
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, aw_hold_r, w_hold_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r, wdata_r, rd_word;
	logic [7:0] awaddr_r;
	logic [3:0] wstrb_r;
	logic aw_take, w_take, ar_take, wr_do, aw_hold_nxt, w_hold_nxt, rvalid_nxt, rd_err, wr_err;
	logic wr_ctrl, wr_data, rd_stat, rd_data;

	assign aw_take = awvalid & awready_r;
	assign w_take = wvalid & wready_r;
	assign ar_take = arvalid & arready_r;
	assign wr_do = aw_hold_r & w_hold_r & ~bvalid_r;
	assign aw_hold_nxt = aw_take | (aw_hold_r & ~wr_do);
	assign w_hold_nxt = w_take | (w_hold_r & ~wr_do);
	assign rvalid_nxt = ar_take | (rvalid_r & ~rready);
	assign wr_ctrl = wr_do & (awaddr_r == `SMSP_CTRL_OFS) & wstrb_r[0];
	assign wr_data = wr_do & (awaddr_r == `SMSP_DATA_OFS) & wstrb_r[0];
	assign wr_err = (awaddr_r != `SMSP_CTRL_OFS) && (awaddr_r != `SMSP_STAT_OFS)
		&& (awaddr_r != `SMSP_DATA_OFS);
	assign rd_stat = ar_take & (araddr == `SMSP_STAT_OFS);
	assign rd_data = ar_take & (araddr == `SMSP_DATA_OFS);

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_err = 1'b0;
		if (araddr == `SMSP_CTRL_OFS) begin
			rd_word[7:0] = ctrl_r;
		end else if (araddr == `SMSP_STAT_OFS) begin
			rd_word[`SMSP_ST_DONE] = done_r;
			rd_word[`SMSP_ST_OVR] = ovr_r;
			rd_word[`SMSP_ST_FAULT] = fault_r;
			rd_word[`SMSP_ST_TXE] = txe_r;
		end else if (araddr == `SMSP_DATA_OFS) begin
			rd_word[7:0] = rx_r;
		end else begin
			rd_err = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `SMSP_RESP_OKAY;
		end else begin
			awready_r <= ~aw_hold_nxt;
			wready_r <= ~w_hold_nxt;
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			bvalid_r <= wr_do | (bvalid_r & ~bready);
			if (wr_do) begin
				bresp_r <= wr_err ? `SMSP_RESP_SLVERR : `SMSP_RESP_OKAY;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (aw_take) awaddr_r <= awaddr;
		if (w_take) begin
			wdata_r <= wdata;
			wstrb_r <= wstrb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `SMSP_RESP_OKAY;
		end else begin
			arready_r <= ~rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (ar_take) begin
				rdata_r <= rd_word;
				rresp_r <= rd_err ? `SMSP_RESP_SLVERR : `SMSP_RESP_OKAY;
			end
		end
	end

	// serial engine
	assign rate = {ctrl_r.rate_sel_bit2, ctrl_r.rate_sel_bit1, ctrl_r.rate_sel_bit0};
	assign rate_ok = (rate != `SMSP_RATE_OFF_LO) && (rate != `SMSP_RATE_OFF_HI);
	assign is_m = ctrl_r.port_enable & ctrl_r.master_select;
	assign is_s = ctrl_r.port_enable & ~ctrl_r.master_select;
	assign sel = ~pin_stb_r[1] | (ctrl_r.clk_pha & ctrl_r.select_disable);
	assign div_tick = is_m && (state_r == smsp_pkg::smsp_run)
		&& (div_r == half_of(rate) - 7'h01);
	assign edge_ev = is_m ? div_tick : (is_s & sel & pin_chg[0]);
	// leading edge leaves the idle level; phase picks the sampling edge
	assign lead = is_m ? (sck_r == ctrl_r.clk_pol) : (sync3_r[0] != ctrl_r.clk_pol);
	assign samp = ctrl_r.clk_pha ? ~lead : lead;
	assign last = edge_ev & (ecnt_r == `SMSP_LAST_EDGE);
	// agreed miso level one stage early, else divisor 4 sees the previous bit
	assign miso_now = (sync2_r[3] == sync3_r[3]) ? sync3_r[3] : pin_stb_r[3];
	assign din = is_m ? miso_now : pin_stb_r[2];
	// master takes its input at the following edge to cover the synchroniser lag
	assign shift_in = (is_m | (ctrl_r.clk_pha & samp)) ? din : rxb_r;
	assign rx_byte = {sh_r[6:0], shift_in};
	assign start_m = is_m & rate_ok & ~txe_r;
	assign load_idle = (state_r == smsp_pkg::smsp_idle) & ~txe_r & (start_m | is_s);
	assign load_next = last & ~txe_r;
	assign fault_m = is_m & ~ctrl_r.select_disable & ~pin_stb_r[1];
	assign fault_s = is_s & ~(ctrl_r.clk_pha & ctrl_r.select_disable) & pin_chg[1]
		& sync3_r[1] & ((state_r == smsp_pkg::smsp_run) | (ecnt_r != 5'h00));

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) ctrl_nxt = wdata_r[7:0];
		if (fault_m) begin
			ctrl_nxt.port_enable = 1'b0;
			ctrl_nxt.master_select = 1'b0;
		end
		sh_nxt = sh_r;
		if (load_idle) begin
			sh_nxt = buf_r;
		end else if (last) begin
			sh_nxt = txe_r ? rx_byte : buf_r;
		end else if (edge_ev & ~samp & (ecnt_r != 5'h00)) begin
			sh_nxt = rx_byte;
		end
		state_nxt = state_r;
		if (!ctrl_r.port_enable || (is_s && !sel)) begin
			state_nxt = smsp_pkg::smsp_idle;
		end else if (last) begin
			state_nxt = (load_next & is_m) ? smsp_pkg::smsp_run : smsp_pkg::smsp_idle;
		end else if (start_m | (is_s & edge_ev)) begin
			state_nxt = smsp_pkg::smsp_run;
		end
		sck_nxt = div_tick ? ~sck_r : sck_r;
		if (!is_m || (state_r == smsp_pkg::smsp_idle)) sck_nxt = ctrl_r.clk_pol;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `SMSP_CTRL_RST;
			state_r <= smsp_pkg::smsp_idle;
			sh_r <= `SMSP_BYTE_RST;
			sck_r <= 1'b0;
			rxb_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			state_r <= state_nxt;
			sh_r <= sh_nxt;
			sck_r <= sck_nxt;
			if (edge_ev & samp) rxb_r <= din;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || (state_nxt == smsp_pkg::smsp_idle) || last) begin
			ecnt_r <= 5'h00;
		end else if (edge_ev) begin
			ecnt_r <= ecnt_r + 5'h01;
		end
		if (!aresetn || (state_r != smsp_pkg::smsp_run) || div_tick) begin
			div_r <= 7'h00;
		end else begin
			div_r <= div_r + 7'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_r <= `SMSP_BYTE_RST;
			txe_r <= 1'b1;
			rx_r <= `SMSP_BYTE_RST;
			done_r <= 1'b0;
			ovr_r <= 1'b0;
			fault_r <= 1'b0;
			arm_done_r <= 1'b0;
			arm_fault_r <= 1'b0;
		end else begin
			if (wr_data) begin
				buf_r <= wdata_r[7:0];
				txe_r <= 1'b0;
			end else if (load_idle | load_next) begin
				txe_r <= 1'b1;
			end
			if (rd_stat) arm_done_r <= done_r;
			else if (rd_data) arm_done_r <= 1'b0;
			if (rd_stat) arm_fault_r <= fault_r;
			else if (wr_ctrl) arm_fault_r <= 1'b0;
			if (last & done_r) begin
				ovr_r <= 1'b1;
			end else if (last) begin
				rx_r <= rx_byte;
				done_r <= 1'b1;
			end else if (rd_data & arm_done_r) begin
				done_r <= 1'b0;
				ovr_r <= 1'b0;
			end
			if (fault_m | fault_s) fault_r <= 1'b1;
			else if (wr_ctrl & arm_fault_r) fault_r <= 1'b0;
		end
	end

	// pin outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_out <= 1'b0;
			sck_oe <= 1'b0;
			mosi_out <= 1'b0;
			mosi_oe <= 1'b0;
			miso_out <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			sck_out <= sck_nxt;
			sck_oe <= ctrl_nxt.port_enable & ctrl_nxt.master_select;
			mosi_out <= sh_nxt[7];
			mosi_oe <= ctrl_nxt.port_enable & ctrl_nxt.master_select;
			miso_out <= sh_nxt[7];
			miso_oe <= is_s & sel;
		end
	end

	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_stat_seen;
		rd_stat & done_r & ~last;
	endsequence
	sequence s_data_clear;
		rd_data & arm_done_r & ~last;
	endsequence

	a_miso_float:
	assert property (is_s & ~sel |=> ~miso_oe) else $error("unselected slave drives miso");
	a_fault_never:
	assert property (is_m & ctrl_r.select_disable & ~fault_r |=> ~fault_r)
		else $error("mode fault set with select disabled");
	a_fault_kept:
	assert property (fault_r & ~arm_fault_r |=> fault_r) else $error("mode fault lost");
	a_half_period:
	assert property (div_tick |-> div_r == half_of(rate) - 7'h01
		##1 ($changed(sck_r) && !div_tick && div_r == 7'h00))
		else $error("serial clock half period wrong");
	a_done_load:
	assert property (last & ~done_r |=> done_r && rx_r == $past(rx_byte))
		else $error("completion did not load data and flag");
	a_done_clear:
	assert property (s_stat_seen ##[2:40] s_data_clear |=> ~done_r)
		else $error("done flag not cleared by status then data read");
	a_done_hold:
	assert property (done_r & ~(rd_data & arm_done_r) |=> done_r) else $error("done lost");
	a_overrun_keep:
	assert property (last & done_r |=> ovr_r && $stable(rx_r)) else $error("overrun lost");
	a_sck_idle:
	assert property (is_m & state_r == smsp_pkg::smsp_idle |=> sck_out == $past(ctrl_r.clk_pol))
		else $error("idle serial clock at wrong level");
	a_txe_clear:
	assert property (wr_data |=> ~txe_r ##1 (txe_r == $past(load_idle | load_next)))
		else $error("buffer empty after data write");
	a_edge_count:
	assert property (last |=> ecnt_r == 5'h00) else $error("edge counter not reset");
endmodule

// file: smsp_slave_model.sv
// behavioural spi slave facing the port in master mode, phase 0, polarity 0
`timescale 1ns/1ps
module smsp_slave_model (
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel_n,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_byte
);
	logic [7:0] sh_r;
	logic [2:0] cnt_r;
	logic sel_seen_r = 1'b0;
	always @(posedge sck) begin
		if (!sel_n) rx_byte <= {rx_byte[6:0], mosi};
	end
	// first bit is on the line before the first edge
	always @(negedge sck or sel_n) begin
		if (sel_n) begin
			sel_seen_r <= 1'b0;
		end else if (!sel_seen_r) begin
			sel_seen_r <= 1'b1;
			sh_r <= tx_byte;
			cnt_r <= 3'h0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
			sh_r <= (cnt_r == 3'h7) ? tx_byte : {sh_r[6:0], 1'b0};
		end
	end
	// a released line does not keep showing its last bit
	assign miso = sel_n ? ~sh_r[7] : sh_r[7];
endmodule

// file: testbench.sv
// register-level testbench of the spi port in master and slave mode
`timescale 1ns/1ps
`include "smsp_defs.svh"
module testbench;
	logic aclk = 1'b0;
	logic aresetn, awvalid, wvalid, bready, arvalid, rready, ss_n_in, tb_sck, tb_mosi;
	logic awready, wready, bvalid, arready, rvalid, sck_out, sck_oe, mosi_out, mosi_oe;
	logic miso_out, miso_oe, mdl_sel_n, mdl_miso;
	logic [7:0] awaddr, araddr, mdl_tx, mdl_rx, d, g;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [2:0] rt;
	wire sck_in = sck_oe ? sck_out : tb_sck;
	wire mosi_in = mosi_oe ? mosi_out : tb_mosi;
	wire miso_in = miso_oe ? miso_out : mdl_miso;
	int fails = 0;
	int checks_done = 0;
	int cyc = 0;
	int hi_cnt = 0;
	int h0;
	smsp_core i_smsp_core (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .sck_in, .sck_out, .sck_oe, .mosi_in, .mosi_out, .mosi_oe,
		.miso_in, .miso_out, .miso_oe, .ss_n_in);
	smsp_slave_model i_smsp_slave_model (.sck(sck_in), .mosi(mosi_in), .sel_n(mdl_sel_n),
		.tx_byte(mdl_tx), .miso(mdl_miso), .rx_byte(mdl_rx));
	always #2.5 aclk = ~aclk;
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (sck_oe && sck_out) hi_cnt <= hi_cnt + 1;
		if (cyc == 20000) begin
			fails++;
			finish_test();
		end
	end
	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
		logic ta;
		logic tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (awready === 1'b1 && !ta) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1 && !tw) begin
				tw = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		bready <= 1'b0;
		compare({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		dt = rdata;
		rs = rresp;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a, v, r);
		compare(v, exp);
	endtask
	task automatic wait_flag(input int b);
		do rd(`SMSP_STAT_OFS, v, r); while (v[b] !== 1'b1);
	endtask
	// plays the external master at the link clock rate, select low for the whole byte
	task automatic spi_frame(input logic [7:0] o, output logic [7:0] gb);
		ss_n_in <= 1'b0;
		for (int k = 7; k >= 0; k--) begin
			tb_mosi <= o[k];
			repeat (16) @(posedge aclk);
			tb_sck <= 1'b1;
			gb[k] = miso_in;
			repeat (16) @(posedge aclk);
			tb_sck <= 1'b0;
		end
		repeat (16) @(posedge aclk);
		ss_n_in <= 1'b1;
		repeat (16) @(posedge aclk);
	endtask
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, tb_sck, tb_mosi} = 8'h00;
		{awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h00000000, 4'hF};
		{ss_n_in, mdl_sel_n, mdl_tx} = {2'b11, 8'hA5};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(`SMSP_CTRL_OFS, 32'h00000000);
		rchk(`SMSP_STAT_OFS, 32'h00000008);
		rchk(`SMSP_DATA_OFS, 32'h00000000);
		rd(8'h0C, v, r);
		compare({30'h0, r}, {30'h0, `SMSP_RESP_SLVERR});
		wr(8'h0C, 32'h000000FF, `SMSP_RESP_SLVERR);
		$display("test reset values done");
		mdl_sel_n <= 1'b0;
		ss_n_in <= 1'b0;
		for (int i = 1; i < 7; i++) begin
			rt = i[2:0];
			d = 8'h30 + i[7:0];
			wr(`SMSP_CTRL_OFS, {24'h0, rt[2], 3'b111, 2'b00, rt[1:0]}, `SMSP_RESP_OKAY);
			h0 = hi_cnt;
			wr(`SMSP_DATA_OFS, {24'h0, d}, `SMSP_RESP_OKAY);
			wait_flag(`SMSP_ST_DONE);
			compare(32'(hi_cnt - h0), 32'(8 << i));
			compare({29'h0, sck_oe, mosi_oe, sck_out}, 32'h6);
			compare({24'h0, mdl_rx}, {24'h0, d});
			rchk(`SMSP_DATA_OFS, 32'h000000A5);
			rchk(`SMSP_STAT_OFS, 32'h00000008);
		end
		$display("test master rates done");
		wr(`SMSP_CTRL_OFS, 32'h00000071, `SMSP_RESP_OKAY);
		h0 = hi_cnt;
		wr(`SMSP_DATA_OFS, 32'h0000003C, `SMSP_RESP_OKAY);
		wr(`SMSP_DATA_OFS, 32'h000000C3, `SMSP_RESP_OKAY);
		rchk(`SMSP_STAT_OFS, 32'h00000000);
		wait_flag(`SMSP_ST_DONE);
		rchk(`SMSP_DATA_OFS, 32'h000000A5);
		wait_flag(`SMSP_ST_DONE);
		compare(32'(hi_cnt - h0), 32'd32);
		compare({24'h0, mdl_rx}, 32'h000000C3);
		rchk(`SMSP_DATA_OFS, 32'h000000A5);
		mdl_tx <= 8'h96;
		wr(`SMSP_DATA_OFS, 32'h00000011, `SMSP_RESP_OKAY);
		wait_flag(`SMSP_ST_DONE);
		wr(`SMSP_DATA_OFS, 32'h00000022, `SMSP_RESP_OKAY);
		wait_flag(`SMSP_ST_OVR);
		rchk(`SMSP_STAT_OFS, 32'h000000C8);
		rchk(`SMSP_DATA_OFS, 32'h000000A5);
		rchk(`SMSP_STAT_OFS, 32'h00000008);
		$display("test queue and overrun done");
		for (int i = 0; i < 2; i++) begin
			wr(`SMSP_CTRL_OFS, (i == 0) ? 32'h00000070 : 32'h000000F3, `SMSP_RESP_OKAY);
			h0 = hi_cnt;
			wr(`SMSP_DATA_OFS, 32'h00000077, `SMSP_RESP_OKAY);
			repeat (8) rd(`SMSP_STAT_OFS, v, r);
			compare(32'(hi_cnt - h0), 32'h0);
		end
		wr(`SMSP_CTRL_OFS, 32'h00000051, `SMSP_RESP_OKAY);
		rchk(`SMSP_CTRL_OFS, 32'h00000001);
		rchk(`SMSP_STAT_OFS, 32'h00000018);
		wr(`SMSP_CTRL_OFS, 32'h00000000, `SMSP_RESP_OKAY);
		rchk(`SMSP_STAT_OFS, 32'h00000008);
		$display("test refused rates and mode fault done");
		{ss_n_in, mdl_sel_n} <= 2'b11;
		wr(`SMSP_CTRL_OFS, 32'h00000040, `SMSP_RESP_OKAY);
		compare({29'h0, sck_oe, mosi_oe, miso_oe}, 32'h0);
		wr(`SMSP_DATA_OFS, 32'h0000005A, `SMSP_RESP_OKAY);
		spi_frame(8'hE1, g);
		compare({24'h0, g}, 32'h0000005A);
		compare({31'h0, miso_oe}, 32'h0);
		wait_flag(`SMSP_ST_DONE);
		rchk(`SMSP_DATA_OFS, 32'h000000E1);
		spi_frame(8'h0F, g);
		compare({24'h0, g}, 32'h000000E1);
		wait_flag(`SMSP_ST_DONE);
		rchk(`SMSP_DATA_OFS, 32'h0000000F);
		$display("test slave done");
		finish_test();
	end
endmodule
